// >>> logic/dfsp_defs.vh
// constants of the deep fifo serial port
`ifndef DFSP_DEFS_VH
`define DFSP_DEFS_VH
// register byte offsets
`define DFSP_OFF_DATA      8'h00
`define DFSP_OFF_CTRL      8'h04
`define DFSP_OFF_RATE      8'h08
`define DFSP_OFF_STATUS    8'h0C
`define DFSP_OFF_RXTO      8'h10
`define DFSP_OFF_TXTO      8'h14
// control fields
`define DFSP_CTRL_ENABLE   0
`define DFSP_CTRL_REINIT   1
`define DFSP_CTRL_MODE     3:2
`define DFSP_CTRL_PARITY   5:4
`define DFSP_CTRL_DEPTH    7:6
`define DFSP_CTRL_TRIG     9:8
`define DFSP_CTRL_RXTOEN   10
`define DFSP_CTRL_TXTOEN   11
// status flags cleared by writing one
`define DFSP_STAT_W1C      9'h1F8
// line modes
`define DFSP_MODE_FULL     2'h0
`define DFSP_MODE_HALF     2'h1
`define DFSP_MODE_LOOP     2'h2
// parity settings
`define DFSP_PAR_NONE      2'h0
`define DFSP_PAR_ODD       2'h1
`define DFSP_PAR_EVEN      2'h2
// reset values
`define DFSP_RST_RATE      4'h4
`define DFSP_RST_DEPTH     2'h0
`define DFSP_RST_TRIG      2'h3
`define DFSP_RST_TO_MS     16'h03E8
`define DFSP_RATE_MAX      4'hC
// fifo
`define DFSP_FIFO_DEPTH    8'h80
`define DFSP_DEPTH_BASE    8'h10
// bit divisors at 100 MHz: 375000 347200 223200 153600 115200 76800 57600
// 38400 19200 9600 4800 2400 1200 bit/s
`define DFSP_DIV_0         17'h0010B
`define DFSP_DIV_1         17'h00120
`define DFSP_DIV_2         17'h001C0
`define DFSP_DIV_3         17'h0028B
`define DFSP_DIV_4         17'h00364
`define DFSP_DIV_5         17'h00516
`define DFSP_DIV_6         17'h006C8
`define DFSP_DIV_7         17'h00A2C
`define DFSP_DIV_8         17'h01458
`define DFSP_DIV_9         17'h028B1
`define DFSP_DIV_10        17'h05161
`define DFSP_DIV_11        17'h0A2C3
`define DFSP_DIV_12        17'h14585
// timing
`define DFSP_CLK_MHZ       100
`define DFSP_HOLD_NS       800
`define DFSP_HOLD_CYC      ((`DFSP_HOLD_NS * `DFSP_CLK_MHZ) / 1000)
`define DFSP_TICK_MS       10
`define DFSP_TICK_CYC      (`DFSP_TICK_MS * `DFSP_CLK_MHZ * 1000)
`endif

// >>> logic/dfsp_uart.v
// deep fifo serial port with apb registers
//
// Added by the designer: the APB register port and the address map.
`default_nettype none
`include "dfsp_defs.vh"
module dfsp_uart #(
	parameter        HAS_DIFF    = 1,
	parameter [23:0] TICK_CYCLES = `DFSP_TICK_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// serial line
	input  wire        rxd,
	output reg         txd,
	output reg         txDriverEn
);
	localparam IDLE = 3'h0, START = 3'h1, DATA = 3'h2, PAR = 3'h3, STOP = 3'h4;
	localparam integer HOLD_FULL = `DFSP_HOLD_CYC;
	localparam [6:0]   HOLD      = HOLD_FULL[6:0];

	reg         enable;
	reg  [1:0]  mode;
	reg  [1:0]  parity;
	reg  [1:0]  depthSel;
	reg  [1:0]  trigSel;
	reg         rxToEn;
	reg         txToEn;
	reg  [3:0]  rateSel;
	reg  [15:0] rxToMs;
	reg  [15:0] txToMs;
	reg  [8:0]  flags;
	reg  [16:0] bitDiv;
	reg         rdValid;
	// fifos
	reg  [7:0]  txMem [0:127];
	reg  [7:0]  rxMem [0:127];
	reg  [6:0]  txWp;
	reg  [6:0]  txRp;
	reg  [6:0]  rxWp;
	reg  [6:0]  rxRp;
	reg  [7:0]  txCnt;
	reg  [7:0]  rxCnt;
	// transmitter
	reg  [2:0]  txState;
	reg  [16:0] txDivCnt;
	reg  [2:0]  txBit;
	reg  [7:0]  txShift;
	reg         txParBit;
	reg         txLine;
	reg         txDoneEvt;
	reg  [6:0]  holdCnt;
	// receiver
	reg         rxSync1;
	reg         rxSync2;
	reg  [2:0]  rxState;
	reg  [16:0] rxDivCnt;
	reg  [2:0]  rxBit;
	reg  [7:0]  rxShift;
	reg         rxParBad;
	reg         rxPush;
	reg         rxPerr;
	reg         rxFerr;
	reg         rxOerr;
	// timeouts
	reg  [23:0] tickCnt;
	reg  [15:0] rxToCnt;
	reg  [15:0] txToCnt;
	reg  [7:0]  trigLevel;

	wire [7:0]  depth   = `DFSP_DEPTH_BASE << depthSel;
	wire        setup   = psel & ~penable;
	wire        wrAcc   = psel & penable & pwrite;
	wire        rdAcc   = psel & penable & ~pwrite;
	wire        wrData  = wrAcc && paddr == `DFSP_OFF_DATA;
	wire        wrCtrl  = wrAcc && paddr == `DFSP_OFF_CTRL;
	wire        wrStat  = wrAcc && paddr == `DFSP_OFF_STATUS;
	wire        mapped  = paddr == `DFSP_OFF_DATA || paddr == `DFSP_OFF_CTRL ||
	                      paddr == `DFSP_OFF_RATE || paddr == `DFSP_OFF_STATUS ||
	                      paddr == `DFSP_OFF_RXTO || paddr == `DFSP_OFF_TXTO;
	wire [1:0]  effMode = (HAS_DIFF == 0 && mode == `DFSP_MODE_HALF) ?
	                      `DFSP_MODE_FULL : mode;
	wire        loop    = effMode == `DFSP_MODE_LOOP;
	wire        parOn   = parity == `DFSP_PAR_ODD || parity == `DFSP_PAR_EVEN;
	wire        rxIn    = loop ? txLine : rxSync2;
	wire        txPop   = txState == IDLE && enable && txCnt != 8'h00;
	wire        txPush  = wrData && txCnt != `DFSP_FIFO_DEPTH;
	wire        rxPop   = rdAcc && paddr == `DFSP_OFF_DATA && rdValid && rxCnt != 8'h00;
	wire        rxErr   = rxPerr | rxFerr | rxOerr;
	wire        rxTrig  = rxCnt >= trigLevel;
	wire        tick    = tickCnt == TICK_CYCLES - 24'h000001;
	wire [15:0] rxToTgt = rxToMs / 16'h000A;
	wire [15:0] txToTgt = txToMs / 16'h000A;
	wire        rxWait  = rxToEn && rxCnt == 8'h00 && rxState == IDLE;
	wire        txWait  = txToEn && (txCnt != 8'h00 || txState != IDLE);
	wire [8:0]  setFlags = {txWait && txToCnt >= txToTgt, rxWait && rxToCnt >= rxToTgt,
	                        rxOerr, rxFerr, rxPerr, txDoneEvt, 3'h0};

	assign pready = 1'b1;

	always @* begin
		case (rateSel)
		4'h0:    bitDiv = `DFSP_DIV_0;
		4'h1:    bitDiv = `DFSP_DIV_1;
		4'h2:    bitDiv = `DFSP_DIV_2;
		4'h3:    bitDiv = `DFSP_DIV_3;
		4'h4:    bitDiv = `DFSP_DIV_4;
		4'h5:    bitDiv = `DFSP_DIV_5;
		4'h6:    bitDiv = `DFSP_DIV_6;
		4'h7:    bitDiv = `DFSP_DIV_7;
		4'h8:    bitDiv = `DFSP_DIV_8;
		4'h9:    bitDiv = `DFSP_DIV_9;
		4'hA:    bitDiv = `DFSP_DIV_10;
		4'hB:    bitDiv = `DFSP_DIV_11;
		default: bitDiv = `DFSP_DIV_12;
		endcase
		case (trigSel)
		2'h0:    trigLevel = 8'h01;
		2'h1:    trigLevel = depth >> 2;
		2'h2:    trigLevel = depth >> 1;
		default: trigLevel = depth - 8'h02;
		endcase
	end

	// configuration registers
	always @(posedge clk) begin
		if (reset) begin
			enable   <= 1'b0;
			mode     <= `DFSP_MODE_FULL;
			parity   <= `DFSP_PAR_NONE;
			depthSel <= `DFSP_RST_DEPTH;
			trigSel  <= `DFSP_RST_TRIG;
			rxToEn   <= 1'b0;
			txToEn   <= 1'b0;
			rateSel  <= `DFSP_RST_RATE;
			rxToMs   <= `DFSP_RST_TO_MS;
			txToMs   <= `DFSP_RST_TO_MS;
		end else begin
			if (wrCtrl) begin
				enable   <= pwdata[`DFSP_CTRL_ENABLE];
				parity   <= pwdata[`DFSP_CTRL_PARITY];
				depthSel <= pwdata[`DFSP_CTRL_DEPTH];
				trigSel  <= pwdata[`DFSP_CTRL_TRIG];
				if (pwdata[`DFSP_CTRL_REINIT]) begin
					mode    <= `DFSP_MODE_FULL;
					rateSel <= `DFSP_RST_RATE;
					rxToEn  <= 1'b0;
					txToEn  <= 1'b0;
					rxToMs  <= `DFSP_RST_TO_MS;
					txToMs  <= `DFSP_RST_TO_MS;
				end else begin
					mode   <= pwdata[`DFSP_CTRL_MODE];
					rxToEn <= pwdata[`DFSP_CTRL_RXTOEN];
					txToEn <= pwdata[`DFSP_CTRL_TXTOEN];
				end
			end
			if (wrAcc && paddr == `DFSP_OFF_RATE && pwdata[3:0] <= `DFSP_RATE_MAX)
				rateSel <= pwdata[3:0];
			if (wrAcc && paddr == `DFSP_OFF_RXTO)
				rxToMs <= pwdata[15:0];
			if (wrAcc && paddr == `DFSP_OFF_TXTO)
				txToMs <= pwdata[15:0];
		end
	end

	// read data and error answer are fixed in the setup cycle
	always @(posedge clk) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			rdValid <= 1'b0;
			flags   <= 9'h000;
		end else begin
			// a new event wins over a clear in the same cycle
			flags <= (flags & ~(wrStat ? (pwdata[8:0] & `DFSP_STAT_W1C) : 9'h000)) |
			         setFlags;
			if (setup) begin
				pslverr <= ~mapped;
				rdValid <= rxCnt != 8'h00;
				case (paddr)
				`DFSP_OFF_DATA:   prdata <= {24'h000000, rxCnt != 8'h00 ? rxMem[rxRp] : 8'h00};
				`DFSP_OFF_CTRL:   prdata <= {20'h00000, txToEn, rxToEn, trigSel, depthSel,
				                             parity, mode, 1'b0, enable};
				`DFSP_OFF_RATE:   prdata <= {28'h0000000, rateSel};
				`DFSP_OFF_STATUS: prdata <= {8'h00, rxCnt, 7'h00, flags[8:3],
				                             txCnt == `DFSP_FIFO_DEPTH, rxCnt == 8'h00, rxTrig};
				`DFSP_OFF_RXTO:   prdata <= {16'h0000, rxToMs};
				`DFSP_OFF_TXTO:   prdata <= {16'h0000, txToMs};
				default:          prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// fifos
	always @(posedge clk) begin
		if (txPush)
			txMem[txWp] <= pwdata[7:0];
		if (rxPush)
			rxMem[rxWp] <= rxShift;
	end

	always @(posedge clk) begin
		if (reset) begin
			txWp  <= 7'h00;
			txRp  <= 7'h00;
			txCnt <= 8'h00;
			rxWp  <= 7'h00;
			rxRp  <= 7'h00;
			rxCnt <= 8'h00;
		end else begin
			if (txPush)
				txWp <= txWp + 7'h01;
			if (txPop)
				txRp <= txRp + 7'h01;
			txCnt <= txCnt + {7'h00, txPush} - {7'h00, txPop};
			if (rxErr) begin
				rxWp  <= 7'h00;
				rxRp  <= 7'h00;
				rxCnt <= 8'h00;
			end else begin
				if (rxPush)
					rxWp <= rxWp + 7'h01;
				if (rxPop)
					rxRp <= rxRp + 7'h01;
				rxCnt <= rxCnt + {7'h00, rxPush} - {7'h00, rxPop};
			end
		end
	end

	// transmitter, free running with no handshake from the far end
	always @(posedge clk) begin
		if (reset) begin
			txState   <= IDLE;
			txDivCnt  <= 17'h00000;
			txBit     <= 3'h0;
			txShift   <= 8'h00;
			txParBit  <= 1'b0;
			txLine    <= 1'b1;
			txDoneEvt <= 1'b0;
		end else begin
			txDoneEvt <= 1'b0;
			if (txState != IDLE)
				txDivCnt <= (txDivCnt == 17'h00000) ? bitDiv - 17'h00001 : txDivCnt - 17'h00001;
			case (txState)
			IDLE: if (txPop) begin
				txShift  <= txMem[txRp];
				txParBit <= (parity == `DFSP_PAR_ODD) ? ~^txMem[txRp] : ^txMem[txRp];
				txLine   <= 1'b0;
				txDivCnt <= bitDiv - 17'h00001;
				txState  <= START;
			end
			START: if (txDivCnt == 17'h00000) begin
				txLine  <= txShift[0];
				txShift <= {1'b0, txShift[7:1]};
				txBit   <= 3'h0;
				txState <= DATA;
			end
			DATA: if (txDivCnt == 17'h00000) begin
				if (txBit == 3'h7) begin
					txLine  <= parOn ? txParBit : 1'b1;
					txState <= parOn ? PAR : STOP;
				end else begin
					txLine  <= txShift[0];
					txShift <= {1'b0, txShift[7:1]};
					txBit   <= txBit + 3'h1;
				end
			end
			PAR: if (txDivCnt == 17'h00000) begin
				txLine  <= 1'b1;
				txState <= STOP;
			end
			STOP: if (txDivCnt == 17'h00000) begin
				txState   <= IDLE;
				txDoneEvt <= txCnt == 8'h00;
			end
			default: txState <= IDLE;
			endcase
		end
	end

	// line driver control
	always @(posedge clk) begin
		if (reset) begin
			txd        <= 1'b1;
			txDriverEn <= 1'b0;
			holdCnt    <= 7'h00;
		end else begin
			txd <= (enable && !loop) ? txLine : 1'b1;
			if (txPop || txState != IDLE)
				holdCnt <= HOLD;
			else if (holdCnt != 7'h00)
				holdCnt <= holdCnt - 7'h01;
			if (!enable || loop)
				txDriverEn <= 1'b0;
			else if (effMode == `DFSP_MODE_HALF)
				txDriverEn <= txPop || txState != IDLE || holdCnt > 7'h01;
			else
				txDriverEn <= 1'b1;
		end
	end

	// receiver
	always @(posedge clk) begin
		if (reset) begin
			rxSync1  <= 1'b1;
			rxSync2  <= 1'b1;
			rxState  <= IDLE;
			rxDivCnt <= 17'h00000;
			rxBit    <= 3'h0;
			rxShift  <= 8'h00;
			rxParBad <= 1'b0;
			rxPush   <= 1'b0;
			rxPerr   <= 1'b0;
			rxFerr   <= 1'b0;
			rxOerr   <= 1'b0;
		end else begin
			rxSync1 <= rxd;
			rxSync2 <= rxSync1;
			rxPush  <= 1'b0;
			rxPerr  <= 1'b0;
			rxFerr  <= 1'b0;
			rxOerr  <= 1'b0;
			if (rxState != IDLE)
				rxDivCnt <= (rxDivCnt == 17'h00000) ? bitDiv - 17'h00001 : rxDivCnt - 17'h00001;
			case (rxState)
			IDLE: if (enable && !rxIn) begin
				rxDivCnt <= bitDiv >> 1;
				rxParBad <= 1'b0;
				rxState  <= START;
			end
			START: if (rxDivCnt == 17'h00000) begin
				rxBit   <= 3'h0;
				rxState <= rxIn ? IDLE : DATA;
			end
			DATA: if (rxDivCnt == 17'h00000) begin
				rxShift <= {rxIn, rxShift[7:1]};
				rxBit   <= rxBit + 3'h1;
				if (rxBit == 3'h7)
					rxState <= parOn ? PAR : STOP;
			end
			PAR: if (rxDivCnt == 17'h00000) begin
				rxParBad <= rxIn != ((parity == `DFSP_PAR_ODD) ? ~^rxShift : ^rxShift);
				rxState  <= STOP;
			end
			STOP: if (rxDivCnt == 17'h00000) begin
				rxState <= IDLE;
				rxPerr  <= rxParBad;
				rxFerr  <= ~rxIn;
				rxOerr  <= rxCnt == `DFSP_FIFO_DEPTH;
				rxPush  <= ~rxParBad && rxIn && rxCnt != `DFSP_FIFO_DEPTH;
			end
			default: rxState <= IDLE;
			endcase
		end
	end

	// timeouts count whole 10 ms ticks
	always @(posedge clk) begin
		if (reset) begin
			tickCnt <= 24'h000000;
			rxToCnt <= 16'h0000;
			txToCnt <= 16'h0000;
		end else begin
			tickCnt <= tick ? 24'h000000 : tickCnt + 24'h000001;
			if (!rxWait)
				rxToCnt <= 16'h0000;
			else if (tick && rxToCnt < rxToTgt)
				rxToCnt <= rxToCnt + 16'h0001;
			if (!txWait)
				txToCnt <= 16'h0000;
			else if (tick && txToCnt < txToTgt)
				txToCnt <= txToCnt + 16'h0001;
		end
	end
endmodule // dfsp_uart
`default_nettype wire

// >>> tb/dfsp_uart_sva.sv
// assertion checker for the deep fifo serial port
`default_nettype none
`include "dfsp_defs.vh"
module dfsp_uart_sva #(
	parameter        HAS_DIFF    = 1,
	parameter [23:0] TICK_CYCLES = 24'h0F4240
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// line
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        txDriverEn
);
	logic       ctrlEn;
	logic [1:0] ctrlMode;
	logic [9:0] highCnt;
	logic       mapped;
	logic       halfOn;
	logic       loopOn;
	logic       fullOn;
	assign mapped = paddr <= `DFSP_OFF_TXTO && paddr[1:0] == 2'h0;
	assign halfOn = ctrlEn && HAS_DIFF != 0 && ctrlMode == `DFSP_MODE_HALF;
	assign loopOn = ctrlEn && ctrlMode == `DFSP_MODE_LOOP;
	assign fullOn = ctrlEn && !halfOn && !loopOn;
	// mirror of the control fields that steer the line
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrlEn <= 1'b0;
			ctrlMode <= `DFSP_MODE_FULL;
		end else if (psel && penable && pwrite && paddr == `DFSP_OFF_CTRL) begin
			ctrlEn <= pwdata[`DFSP_CTRL_ENABLE];
			ctrlMode <= pwdata[`DFSP_CTRL_REINIT] ? `DFSP_MODE_FULL : pwdata[`DFSP_CTRL_MODE];
		end
	end
	// length of the current high stretch on the line, saturating
	always_ff @(posedge clk) begin
		if (reset || !txd) begin
			highCnt <= 10'h000;
		end else if (highCnt != 10'h3FF) begin
			highCnt <= highCnt + 10'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_xfer(logic ok);
		psel && !penable && mapped == ok ##1 psel && penable;
	endsequence
	a_apb_mapped: assert property (s_xfer(1'b1) |-> pready && !pslverr)
		else $error("mapped access refused");
	a_apb_unmapped: assert property (s_xfer(1'b0) |-> pready && pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> txd && !txDriverEn)
		else $error("line busy after reset");
	a_start_driven: assert property ($fell(txd) |-> txDriverEn)
		else $error("start bit without driver");
	a_half_hold: assert property (halfOn && $fell(txDriverEn) |-> highCnt >= 10'h04F)
		else $error("driver released too early");
	// bound holds for the faster rates only
	a_half_release: assert property (halfOn && highCnt == 10'h3E8 |-> !txDriverEn)
		else $error("driver held while idle");
	a_loop_quiet: assert property (loopOn && $past(loopOn, 2) |-> txd && !txDriverEn)
		else $error("line driven in loopback");
	a_off_quiet: assert property (!ctrlEn && !$past(ctrlEn) |-> txd && !txDriverEn)
		else $error("line driven while disabled");
	a_full_drive: assert property (fullOn && $past(fullOn, 2) |-> txDriverEn)
		else $error("driver off in full duplex");
endmodule // dfsp_uart_sva
bind dfsp_uart dfsp_uart_sva #(.HAS_DIFF(HAS_DIFF), .TICK_CYCLES(TICK_CYCLES)) u_sva (
	.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxd(rxd), .txd(txd), .txDriverEn(txDriverEn));
`default_nettype wire

// >>> tb/dfsp_remote_node.sv
// remote serial node model at the far end of the line
`default_nettype none
module dfsp_remote_node #(
	parameter int BIT_CYC = 267
) (
	// clock
	input  wire logic clk,
	// line
	input  wire logic txd,
	output var  logic rxd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       parOn = 1'b0;
	logic [7:0] lastByte;
	logic       lastPar;
	logic       lastStop;
	int         gotCnt = 0;
	initial rxd = 1'b1;
	// sample each data, parity and stop bit at its centre
	initial forever begin
		@(posedge clk);
		if (txd === 1'b0) begin
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				lastByte[i] = txd;
			end
			if (parOn) begin
				repeat (BIT_CYC) @(posedge clk);
				lastPar = txd;
			end
			repeat (BIT_CYC) @(posedge clk);
			lastStop = txd;
			gotCnt++;
		end
	end
	task automatic send_char(input logic [7:0] b, input logic par, input logic stop);
		logic [10:0] f;
		f = parOn ? {stop, par, b, 1'b0} : {1'b1, stop, b, 1'b0};
		for (int i = 0; i < (parOn ? 11 : 10); i++) begin
			rxd <= f[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		rxd <= 1'b1;
		@(posedge clk);
	endtask
endmodule // dfsp_remote_node
`default_nettype wire

// >>> tb/dfsp_uart_tb.sv
// self-checking bench of the deep fifo serial port
`default_nettype none
`include "dfsp_defs.vh"
module dfsp_uart_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BC = 267;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, rxd, txd, txDriverEn;
	logic        errv;
	logic        txDriverEn2;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [7:0]  txb [3] = '{8'h01, 8'h8C, 8'h5B};
	int          fails = 0;
	int          cmp_count = 0;
	dfsp_uart #(.HAS_DIFF(1), .TICK_CYCLES(24'h000064)) DUT (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.txDriverEn(txDriverEn));
	// instance without differential transceivers, sharing the bus
	dfsp_uart #(.HAS_DIFF(0), .TICK_CYCLES(24'h000064)) DUT2 (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .rxd(rxd), .txd(),
		.txDriverEn(txDriverEn2));
	dfsp_remote_node #(.BIT_CYC(BC)) node (.clk(clk), .txd(txd), .rxd(rxd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: %s got %h", $time, s, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n, 1, "access length");
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e, input string s);
		apb(1'b0, a, 32'h0);
		chk(rdv & m, e, s);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_tx;
		int n0;
		int k;
		n0 = node.gotCnt;
		k = 0;
		while (node.gotCnt == n0 && k < 6000) begin
			@(posedge clk);
			k++;
		end
		chk(k < 6000, 1, "frame seen");
	endtask
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cyc(10);
		reset <= 1'b0;
		cyc(1);
		rc(`DFSP_OFF_CTRL, 32'hFFF, 32'h300, "ctrl");
		rc(`DFSP_OFF_RATE, 32'hF, 32'h4, "rate");
		rc(`DFSP_OFF_RXTO, 32'hFFFF, 32'h3E8, "rx duration");
		rc(`DFSP_OFF_TXTO, 32'hFFFF, 32'h3E8, "tx duration");
		rc(`DFSP_OFF_STATUS, 32'hFF01FF, 32'h2, "status");
		rc(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
		chk(errv, 1, "unmapped error");
		$display("test reset values done");
		apb(1'b1, `DFSP_OFF_RATE, 32'h0);
		apb(1'b1, `DFSP_OFF_RATE, 32'hD);
		rc(`DFSP_OFF_RATE, 32'hF, 32'h0, "rate kept");
		for (int p = 0; p < 3; p++) begin
			node.parOn = (p != 0);
			apb(1'b1, `DFSP_OFF_CTRL, 32'h1 | (32'(p) << 4));
			apb(1'b1, `DFSP_OFF_DATA, {24'h0, txb[p]});
			wait_tx();
			chk(node.lastByte, txb[p], "tx byte");
			chk(node.lastStop, 1, "tx stop");
			if (p != 0) chk(node.lastPar, (p == 1) ? ~^txb[p] : ^txb[p], "parity");
			cyc(BC);
			rc(`DFSP_OFF_STATUS, 32'h8, 32'h8, "tx done");
			apb(1'b1, `DFSP_OFF_STATUS, 32'h8);
		end
		$display("test transmit done");
		node.parOn = 1'b0;
		apb(1'b1, `DFSP_OFF_CTRL, 32'h5);
		cyc(1);
		chk(txDriverEn, 0, "driver idle");
		apb(1'b1, `DFSP_OFF_DATA, 32'h5A);
		wait_tx();
		// about 40 cycles into the hold after the stop bit
		cyc(173);
		chk(txDriverEn, 1, "driver hold");
		cyc(800);
		chk(txDriverEn, 0, "driver release");
		chk(txDriverEn2, 1, "duplex choice ignored");
		$display("test half duplex done");
		node.parOn = 1'b1;
		apb(1'b1, `DFSP_OFF_CTRL, 32'h21);
		node.send_char(8'h3C, ^8'h3C, 1'b1);
		cyc(20);
		rc(`DFSP_OFF_STATUS, 32'hFF0003, 32'h010001, "level one");
		apb(1'b1, `DFSP_OFF_CTRL, 32'h61);
		apb(1'b1, `DFSP_OFF_CTRL, 32'h161);
		rc(`DFSP_OFF_CTRL, 32'h3C0, 32'h140, "depth and trigger");
		rc(`DFSP_OFF_STATUS, 32'h1, 32'h0, "quarter level");
		rc(`DFSP_OFF_DATA, 32'hFF, 32'h3C, "rx byte");
		for (int e = 0; e < 2; e++) begin
			node.send_char(8'h11, ^8'h11, 1'b1);
			node.send_char(8'h11, (e == 0) ^ (^8'h11), e == 0);
			cyc(20);
			rc(`DFSP_OFF_STATUS, 32'hFF0032, e == 0 ? 32'h12 : 32'h22, "rx flush");
			apb(1'b1, `DFSP_OFF_STATUS, 32'h30);
		end
		$display("test receive done");
		apb(1'b1, `DFSP_OFF_TXTO, 32'hA);
		apb(1'b1, `DFSP_OFF_CTRL, 32'h829);
		apb(1'b1, `DFSP_OFF_DATA, 32'h96);
		cyc(11 * BC + 100);
		rc(`DFSP_OFF_DATA, 32'hFF, 32'h96, "loopback");
		rc(`DFSP_OFF_STATUS, 32'h100, 32'h100, "tx timeout");
		apb(1'b1, `DFSP_OFF_RXTO, 32'h5);
		apb(1'b1, `DFSP_OFF_CTRL, 32'h401);
		cyc(300);
		rc(`DFSP_OFF_STATUS, 32'h80, 32'h80, "zero timeout");
		// 25 ms truncates to two ticks
		apb(1'b1, `DFSP_OFF_RXTO, 32'h19);
		apb(1'b1, `DFSP_OFF_STATUS, 32'h80);
		rc(`DFSP_OFF_STATUS, 32'h80, 32'h0, "timeout restarted");
		cyc(250);
		rc(`DFSP_OFF_STATUS, 32'h80, 32'h80, "truncated timeout");
		apb(1'b1, `DFSP_OFF_CTRL, 32'h40B);
		rc(`DFSP_OFF_RATE, 32'hF, 32'h4, "reinit rate");
		rc(`DFSP_OFF_RXTO, 32'hFFFF, 32'h3E8, "reinit duration");
		rc(`DFSP_OFF_TXTO, 32'hFFFF, 32'h3E8, "reinit tx duration");
		rc(`DFSP_OFF_CTRL, 32'hC0F, 32'h1, "reinit ctrl");
		apb(1'b1, `DFSP_OFF_CTRL, 32'h0);
		cyc(3);
		chk({txd, txDriverEn}, 32'h2, "line released");
		$display("test modes done");
		close_out();
	end
	initial begin
		cyc(60000);
		fails++;
		$display("unexpected at %0t: watchdog", $time);
		close_out();
	end
endmodule // dfsp_uart_tb
`default_nettype wire
